// [bench/scs_slave_model.sv]
// Behavioural serial slave on one select line
`timescale 1ns/1ps
`default_nettype none
module scs_slave_model (
  // Serial link
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  // Setup
  input  wire logic        idle_pol_in,
  input  wire logic        phase_in,
  input  wire logic [4:0]  nbits_in,
  input  wire logic [15:0] reply_in,
  output logic [15:0]      got_out
);
  int idx = 0;
  // Delayed select, so a select rising with the last edge still counts
  logic sel_q = 1'b1;
  always @(cs_n_in) sel_q <= cs_n_in;
  initial miso_out = 1'b0;
  initial got_out = 16'h0000;
  // Phase 1 needs the first bit before any edge
  always @(negedge cs_n_in) begin
    idx = 0;
    got_out = 16'h0000;
    if (phase_in) miso_out = reply_in[nbits_in-1];
  end
  // Released line must not keep its last value
  always @(posedge cs_n_in) miso_out = ~miso_out;
  always @(sclk_in) begin
    if (sel_q === 1'b0 && idx < nbits_in) begin
      if ((sclk_in !== idle_pol_in) === phase_in) begin
        got_out = {got_out[14:0], mosi_in};
        idx++;
      end else begin
        miso_out = reply_in[nbits_in-1-idx];
      end
    end
  end
endmodule
`default_nettype wire

// [bench/spi_chip_select_timing_and_irq_mask_tb_top.sv]
// Self-checking bench of the serial peripheral master
`timescale 1ns/1ps
`default_nettype none
module spi_chip_select_timing_and_irq_mask_tb_top;
  logic              sys_clk_in;
  logic              reset_n_in;
  scs_pkg::scs_bus_t bus;
  logic [31:0]       rdata;
  logic [9:0]        status_ext;
  logic              sclk;
  logic              mosi;
  logic              miso;
  logic [3:0]        sel_n;
  logic              irq;
  logic              pol;
  logic              pha;
  logic [4:0]        nbits;
  logic [15:0]       reply;
  logic [15:0]       got;
  int                miscompares = 0;
  int                tests_run = 0;

  scs_spi_master i_scs_spi_master (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bus_in(bus),
    .rdata_out(rdata), .status_ext_in(status_ext),
    .serial_clock_out(sclk), .mosi_out(mosi), .miso_in(miso),
    .periph_select_lines_n_out(sel_n), .irq_out(irq));
  scs_slave_model i_scs_slave_model (
    .sclk_in(sclk), .cs_n_in(sel_n[0]), .mosi_in(mosi), .miso_out(miso),
    .idle_pol_in(pol), .phase_in(pha), .nbits_in(nbits), .reply_in(reply),
    .got_out(got));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] v, lo, hi, input string m);
    tests_run++;
    if ((v >= lo && v <= hi) !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s got %0h", $time, m, v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic xfer(input logic [15:0] d, input logic [1:0] cs,
                      input logic last);
    wr(scs_pkg::OFF_TXD, {7'h00, last, 6'h00, cs, d});
  endtask

  // Bounded so a stuck select cannot hang the run
  task automatic wait_idle;
    int n = 0;
    repeat (4) @(posedge sys_clk_in);
    while (sel_n !== 4'hf && n < 3000) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(n, 0, 2999, "select stuck");
  endtask

  task automatic t_reset;
    logic [31:0] d;
    rd(scs_pkg::OFF_CFG, d);
    chk(d, 0, 0, "cfg reset");
    rd(scs_pkg::OFF_MASK, d);
    chk(d, 0, 0, "mask reset");
    rd(8'h44, d);
    chk(d, 0, 0, "unmapped read");
    chk(sclk, 0, 0, "idle clock");
    wr(scs_pkg::OFF_CFG, 32'h1234_5678);
    rd(scs_pkg::OFF_CFG, d);
    chk(d, 32'h1234_5678, 32'h1234_5678, "cfg readback");
    $display("test reset done");
  endtask

  task automatic t_mask;
    logic [31:0] d;
    wr(scs_pkg::OFF_IER, 32'h0000_03ff);
    rd(scs_pkg::OFF_MASK, d);
    chk(d, 32'h3ff, 32'h3ff, "mask set");
    wr(scs_pkg::OFF_IDR, 32'h0000_0155);
    rd(scs_pkg::OFF_MASK, d);
    chk(d, 32'h2aa, 32'h2aa, "mask clear");
    wr(scs_pkg::OFF_IER, 32'h0000_0000);
    wr(scs_pkg::OFF_MASK, 32'h0000_0000);
    rd(scs_pkg::OFF_MASK, d);
    chk(d, 32'h2aa, 32'h2aa, "zero write");
    wr(scs_pkg::OFF_IDR, 32'h0000_03ff);
    status_ext <= 10'h100;
    repeat (4) @(posedge sys_clk_in);
    #1 chk(irq, 0, 0, "masked irq");
    wr(scs_pkg::OFF_IER, 32'h0000_0100);
    repeat (3) @(posedge sys_clk_in);
    #1 chk(irq, 1, 1, "irq raised");
    wr(scs_pkg::OFF_IDR, 32'h0000_03ff);
    status_ext <= 10'h000;
    // Idle link sets the all-empty source at bit 9
    wr(scs_pkg::OFF_IER, 32'h0000_0200);
    repeat (3) @(posedge sys_clk_in);
    #1 chk(irq, 1, 1, "idle irq");
    wr(scs_pkg::OFF_IDR, 32'h0000_03ff);
    $display("test mask done");
  endtask

  task automatic t_modes;
    logic [31:0] d;
    logic [15:0] m;
    for (int i = 0; i < 5; i++) begin
      m = 16'hffff >> (8 - 2 * i);
      pol = i[0];
      pha = i[1];
      nbits = 5'(8 + 2 * i);
      reply = 16'h3c5a & m;
      wr(scs_pkg::OFF_CFG, {16'h0000, 8'd8, 4'(2 * i), 2'b00, pha, pol});
      xfer(16'ha5c3 & m, 2'd0, 1'b1);
      wait_idle;
      chk(got, 16'ha5c3 & m, 16'ha5c3 & m, "sent word");
      rd(scs_pkg::OFF_RXD, d);
      chk(d, reply, reply, "received word");
      chk(sclk, pol, pol, "idle level");
    end
    pol = 1'b0;
    pha = 1'b0;
    nbits = 5'd8;
    $display("test modes done");
  endtask

  // Lead, period and tail counted in master clock cycles
  task automatic t_tim(input logic [31:0] c, input int el, ep, eg);
    int n = 0, fall = -1, rise = -1, e1 = 0, e3 = 0, last = 0, ne = 0;
    logic p;
    wr(scs_pkg::OFF_CFG, c);
    xfer(16'h00a5, 2'd0, 1'b1);
    p = sclk;
    while (rise < 0 && n < 3000) begin
      @(posedge sys_clk_in);
      #1 n++;
      if (fall < 0 && sel_n[0] === 1'b0) fall = n;
      if (sclk !== p) begin
        ne++;
        last = n;
        if (ne == 1) e1 = n;
        if (ne == 3) e3 = n;
        p = sclk;
      end
      if (fall >= 0 && sel_n[0] === 1'b1) rise = n;
    end
    chk(e1 - fall, el, el + 2, "lead");
    chk(e3 - e1, ep, ep, "period");
    chk(rise - last, eg, eg + 2, "tail gap");
    $display("test timing done");
  endtask

  task automatic t_ovr;
    logic [31:0] d;
    wr(scs_pkg::OFF_CFG, {16'h0000, 8'd4, 8'h00});
    rd(scs_pkg::OFF_RXD, d);
    rd(scs_pkg::OFF_SR, d);
    xfer(16'h0011, 2'd0, 1'b1);
    wait_idle;
    xfer(16'h0022, 2'd0, 1'b1);
    wait_idle;
    rd(scs_pkg::OFF_SR, d);
    chk(d[3], 1, 1, "overrun set");
    chk(d[0], 1, 1, "rx full");
    rd(scs_pkg::OFF_SR, d);
    chk(d[3], 0, 0, "overrun cleared");
    chk(d, 32'h203, 32'h203, "status idle");
    $display("test overrun done");
  endtask

  task automatic t_hold;
    wr(scs_pkg::OFF_CFG, {16'h0000, 8'd4, 8'h08});
    xfer(16'h0033, 2'd0, 1'b0);
    repeat (80) @(posedge sys_clk_in);
    chk(sel_n, 4'he, 4'he, "select held");
    xfer(16'h0044, 2'd1, 1'b0);
    repeat (80) @(posedge sys_clk_in);
    chk(sel_n, 4'hd, 4'hd, "select moved");
    xfer(16'h0055, 2'd1, 1'b0);
    xfer(16'h0066, 2'd1, 1'b1);
    wait_idle;
    chk(sel_n, 4'hf, 4'hf, "select released");
    $display("test hold done");
  endtask

  initial begin
    reset_n_in = 1'b0;
    bus = '0;
    status_ext = 10'h000;
    pol = 1'b0;
    pha = 1'b0;
    nbits = 5'd8;
    reply = 16'h0000;
    repeat (6) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    t_reset;
    t_mask;
    t_modes;
    t_tim({8'd0, 8'd5, 8'd6, 8'h00}, 5, 6, 0);
    t_tim({8'd0, 8'd0, 8'd6, 8'h00}, 3, 6, 0);
    t_tim({8'd0, 8'd1, 8'd1, 8'h04}, 32, 32, 0);
    t_tim({8'd1, 8'd0, 8'd4, 8'h00}, 2, 4, 34);
    t_tim({8'd1, 8'd0, 8'd1, 8'h04}, 16, 32, 1040);
    t_ovr;
    t_hold;
    final_report;
  end

  // Whole run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    miscompares++;
    final_report;
  end
endmodule
`default_nettype wire

// [logic/scs_pkg.sv]
// Shared types and constants of the serial peripheral master
package scs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_RXD = 8'h08;
  localparam logic [7:0] OFF_TXD = 8'h0c;
  localparam logic [7:0] OFF_SR  = 8'h10;
  localparam logic [7:0] OFF_IER = 8'h14;
  localparam logic [7:0] OFF_IDR = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1c;
  localparam logic [7:0] OFF_CFG = 8'h30;
  // Transmit word fields
  localparam int TXD_CS_LSB   = 16;
  localparam int TXD_LAST_BIT = 24;
  // Reset values
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [9:0]  MASK_RST = 10'h000;
  // Status bits fed from outside the block
  localparam logic [9:0]  EXT_BITS = 10'h1f4;
  // Timing figures
  localparam int FAST_DIV_N = 32;
  localparam int GAP_UNIT  = 32;
  localparam int CHAR_BASE = 8;
  localparam int CNT_W     = 20;

  typedef struct packed {
    logic [7:0] inter_char_delay;
    logic [7:0] cs_to_clock_delay;
    logic [7:0] serial_clock_divider;
    logic [3:0] char_len;
    logic       cs_hold_after_xfer;
    logic       fast_divide;
    logic       capture_phase;
    logic       clock_polarity;
  } scs_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_SHIFT = 2'b11,
    ST_GAP   = 2'b10
  } scs_fsm_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scs_bus_t;

  typedef struct packed {
    scs_fsm_t         fsm;
    scs_cfg_t         cfg;
    logic [9:0]       mask;
    logic             ovr;
    logic             rxf;
    logic [15:0]      rxd;
    logic [15:0]      txd;
    logic [1:0]       tx_cs;
    logic             tx_last;
    logic             txv;
    logic             cs_on;
    logic [1:0]       cs_idx;
    logic             last_q;
    logic [15:0]      sh_tx;
    logic [15:0]      sh_rx;
    logic [4:0]       e;
    logic [CNT_W-1:0] cnt;
    logic             sck;
    logic             mosi;
    logic             irq;
    logic [31:0]      rdata;
    logic             mi1;
    logic             mi2;
  } scs_st_t;
endpackage

// [logic/scs_spi_master.sv]
// Serial peripheral master with character timing and interrupt mask
`timescale 1ns/1ps
`default_nettype none
module scs_spi_master (
  // Clock and reset
  input  wire logic            sys_clk_in,
  input  wire logic            reset_n_in,
  // Register port
  input  wire scs_pkg::scs_bus_t bus_in,
  output logic [31:0]          rdata_out,
  // Status sources kept outside this block
  input  wire logic [9:0]      status_ext_in,
  // Serial link
  output logic                 serial_clock_out,
  output logic                 mosi_out,
  input  wire logic            miso_in,
  output logic [3:0]           periph_select_lines_n_out,
  // Interrupt
  output logic                 irq_out
);
  localparam int CW = scs_pkg::CNT_W;

  scs_pkg::scs_st_t q;
  scs_pkg::scs_st_t d;
  logic             rst_s1;
  logic             rst_n;
  logic [9:0]       stat;
  logic             rx_read;
  logic             rx_load;

  function automatic logic [12:0] per_f(scs_pkg::scs_cfg_t c);
    if (c.fast_divide)
      return 13'(c.serial_clock_divider * scs_pkg::FAST_DIV_N);
    return {5'h00, c.serial_clock_divider};
  endfunction

  // Counts hold cycles minus one, never below one cycle
  function automatic logic [CW-1:0] lo_f(scs_pkg::scs_cfg_t c);
    logic [CW-1:0] h;
    h = CW'(per_f(c) >> 1);
    return (h == '0) ? '0 : h - 1'b1;
  endfunction

  function automatic logic [CW-1:0] hi_f(scs_pkg::scs_cfg_t c);
    logic [CW-1:0] h;
    h = CW'(per_f(c) - (per_f(c) >> 1));
    return (h == '0) ? '0 : h - 1'b1;
  endfunction

  function automatic logic [CW-1:0] lead_f(scs_pkg::scs_cfg_t c);
    logic [CW-1:0] s;
    s = c.fast_divide ? CW'(scs_pkg::FAST_DIV_N) : CW'(1);
    if (c.cs_to_clock_delay == 8'h00)
      return hi_f(c);
    return CW'(c.cs_to_clock_delay * s) - 1'b1;
  endfunction

  function automatic logic [CW-1:0] gap_f(scs_pkg::scs_cfg_t c);
    logic [CW-1:0] s;
    s = c.fast_divide ? CW'(scs_pkg::FAST_DIV_N) : CW'(1);
    return CW'(scs_pkg::GAP_UNIT * c.inter_char_delay * s)
           + CW'(per_f(c) >> 1) - 1'b1;
  endfunction

  function automatic logic [4:0] nb_f(scs_pkg::scs_cfg_t c);
    return 5'(c.char_len + scs_pkg::CHAR_BASE);
  endfunction

  // Left-aligns characters of up to 16 bits so the top bit leaves first; longer lengths shift the word out to zero
  function automatic scs_pkg::scs_st_t load_f(scs_pkg::scs_st_t s);
    s.sh_tx  = s.txd << (5'd16 - nb_f(s.cfg));
    s.sh_rx  = '0;
    s.e      = '0;
    s.last_q = s.tx_last;
    s.txv    = 1'b0;
    if (s.cfg.capture_phase) begin
      s.mosi  = s.sh_tx[15];
      s.sh_tx = s.sh_tx << 1;
    end
    return s;
  endfunction

  function automatic scs_pkg::scs_st_t next_f(scs_pkg::scs_st_t s);
    if (s.txv && s.tx_cs == s.cs_idx && !s.last_q) begin
      s     = load_f(s);
      s.fsm = scs_pkg::ST_SHIFT;
      s.cnt = lo_f(s.cfg);
    end else begin
      s.fsm = scs_pkg::ST_IDLE;
      if (!s.cfg.cs_hold_after_xfer || s.last_q)
        s.cs_on = 1'b0;
    end
    return s;
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  assign rx_read = bus_in.rd && bus_in.addr == scs_pkg::OFF_RXD;
  assign rx_load = q.fsm == scs_pkg::ST_SHIFT && q.cnt == '0
                   && q.e == 5'(2 * nb_f(q.cfg) - 1);

  always_comb begin
    stat = (status_ext_in & scs_pkg::EXT_BITS)
         | {!q.txv && q.fsm == scs_pkg::ST_IDLE, 5'h00, q.ovr, 1'b0,
            !q.txv, q.rxf};
  end

  always_comb begin
    d       = q;
    d.rdata = '0;
    d.mi1   = miso_in;
    d.mi2   = q.mi1;
    d.irq   = |(stat & q.mask);
    // Reads and their side effects first, so hardware sets win
    if (bus_in.rd) begin
      case (bus_in.addr)
        scs_pkg::OFF_RXD: begin
          d.rdata = {16'h0000, q.rxd};
          d.rxf   = 1'b0;
        end
        scs_pkg::OFF_SR: begin
          d.rdata = {22'h0, stat};
          d.ovr   = 1'b0;
        end
        scs_pkg::OFF_MASK: d.rdata = {22'h0, q.mask};
        scs_pkg::OFF_CFG: d.rdata = q.cfg;
        default:          d.rdata = '0;
      endcase
    end
    unique case (q.fsm)
      scs_pkg::ST_IDLE: begin
        if (q.txv) begin
          if (q.cs_on && q.cs_idx == q.tx_cs) begin
            d     = load_f(d);
            d.fsm = scs_pkg::ST_SHIFT;
            d.cnt = lo_f(q.cfg);
          end else if (q.cs_on) begin
            d.cs_on = 1'b0;
          end else begin
            d        = load_f(d);
            d.cs_on  = 1'b1;
            d.cs_idx = q.tx_cs;
            d.fsm    = scs_pkg::ST_LEAD;
            d.cnt    = lead_f(q.cfg);
          end
        end
      end
      scs_pkg::ST_LEAD: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - 1'b1;
        end else begin
          // Lead count already spans the wait, first edge comes next
          d.fsm = scs_pkg::ST_SHIFT;
          d.cnt = '0;
        end
      end
      scs_pkg::ST_SHIFT: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - 1'b1;
        end else begin
          d.sck = ~q.sck;
          d.e   = q.e + 1'b1;
          d.cnt = !q.sck ? hi_f(q.cfg) : lo_f(q.cfg);
          if (!q.sck == q.cfg.capture_phase) begin
            d.sh_rx = {q.sh_rx[14:0], q.mi2};
          end else begin
            d.mosi  = q.sh_tx[15];
            d.sh_tx = q.sh_tx << 1;
          end
          if (rx_load) begin
            d.rxd = d.sh_rx;
            d.rxf = 1'b1;
            if (q.rxf && !rx_read)
              d.ovr = 1'b1;
            if (q.cfg.inter_char_delay != 8'h00) begin
              d.fsm = scs_pkg::ST_GAP;
              d.cnt = gap_f(q.cfg);
            end else begin
              d = next_f(d);
            end
          end
        end
      end
      scs_pkg::ST_GAP: begin
        if (q.cnt != '0)
          d.cnt = q.cnt - 1'b1;
        else
          d = next_f(d);
      end
    endcase
    // Writes last, so a new character is not lost to a load
    if (bus_in.wr) begin
      case (bus_in.addr)
        scs_pkg::OFF_CFG: d.cfg = bus_in.wdata;
        scs_pkg::OFF_TXD: begin
          d.txd     = bus_in.wdata[15:0];
          d.tx_cs   = bus_in.wdata[scs_pkg::TXD_CS_LSB +: 2];
          d.tx_last = bus_in.wdata[scs_pkg::TXD_LAST_BIT];
          d.txv     = 1'b1;
        end
        scs_pkg::OFF_IER: d.mask = q.mask | bus_in.wdata[9:0];
        scs_pkg::OFF_IDR: d.mask = q.mask & ~bus_in.wdata[9:0];
        default:          d.mask = q.mask;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.cfg  <= scs_pkg::CFG_RST;
      q.mask <= scs_pkg::MASK_RST;
    end else begin
      q <= d;
    end
  end

  assign serial_clock_out = q.cfg.clock_polarity ^ q.sck;
  assign mosi_out         = q.mosi;
  assign rdata_out        = q.rdata;
  assign irq_out          = q.irq;
  always_comb begin
    for (int i = 0; i < 4; i++)
      periph_select_lines_n_out[i] = !(q.cs_on && q.cs_idx == 2'(i));
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  property p_idle_clk;
    q.fsm == scs_pkg::ST_IDLE |-> serial_clock_out == q.cfg.clock_polarity;
  endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("serial clock not at idle level");

  property p_cs_drop;
    (q.fsm != scs_pkg::ST_IDLE) ##1
      (q.fsm == scs_pkg::ST_IDLE && !q.cfg.cs_hold_after_xfer && !q.txv)
      |-> !q.cs_on;
  endproperty
  a_cs_drop: assert property (p_cs_drop)
    else $error("select held without hold mode");

  property p_edges;
    q.fsm == scs_pkg::ST_SHIFT |-> q.e <= 5'(2 * nb_f(q.cfg) - 1);
  endproperty
  a_edges: assert property (p_edges)
    else $error("too many clock edges in character");

  property p_lead_cnt;
    (q.fsm == scs_pkg::ST_IDLE ##1
      (q.fsm == scs_pkg::ST_LEAD && q.cfg.cs_to_clock_delay != 8'h00
       && $stable(q.cfg))) |-> q.cnt == lead_f(q.cfg);
  endproperty
  a_lead_cnt: assert property (p_lead_cnt)
    else $error("wrong select lead count");

  property p_reset_vals;
    $rose(rst_n) |-> q.cfg.serial_clock_divider == 8'h00 && q.mask == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register not cleared at reset");

  property p_ier;
    bus_in.wr && bus_in.addr == scs_pkg::OFF_IER
      |=> (q.mask & $past(bus_in.wdata[9:0])) == $past(bus_in.wdata[9:0]);
  endproperty
  a_ier: assert property (p_ier)
    else $error("enable write did not set mask");

  property p_ovr;
    rx_load && q.rxf && !rx_read |=> q.ovr && q.rxf;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun missed");

  property p_irq;
    ##1 irq_out == |($past(stat) & $past(q.mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatch");

  property p_nogap;
    rx_load && q.cfg.inter_char_delay == 8'h00 && q.txv && !q.last_q
      && q.tx_cs == q.cs_idx |=> q.fsm == scs_pkg::ST_SHIFT && q.cs_on;
  endproperty
  a_nogap: assert property (p_nogap)
    else $error("gap inserted with zero delay");

  c_char: cover property (rx_load);
  c_gap: cover property (q.fsm == scs_pkg::ST_GAP);
  c_ovr: cover property ($rose(q.ovr));
  c_hold: cover property (q.fsm == scs_pkg::ST_IDLE && q.cs_on);
endmodule
`default_nettype wire
